/* File: verilog/double_speed_clock_generator.sv */
module double_speed_clock_generator
  import clock_speed_pkg::*;
#(
  parameter int NP = num_periph
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        oscillator_input_i,
  input  wire logic        boot_double_speed_fuse_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             core_clk_o,
  output logic             cpu_cycle_o,
  output logic [NP-1:0]    periph_cycle_o,
  output logic             cpu_double_speed_o
);
  typedef struct packed {
    logic [7:0]  ctrl;
    logic        osc_d;
    logic        half;
    logic        eff_cpu;
    logic        core_clk;
    logic        ack;
    logic [31:0] dat;
    logic        boot_done;
  } st_s;
  st_s st_reg, st_next;

  logic            osc_rise;
  logic            half_rise;
  logic [NP-1:0]   per_dbl;
  logic [NP-1:0]   per_cyc;
  logic            cpu_cyc;
  logic            hit;

  // oscillator sampled as synchronous level; each rising edge is one period
  assign osc_rise  = oscillator_input_i & ~st_reg.osc_d;
  assign half_rise = osc_rise & ~st_reg.half;
  assign hit       = (adr_i[9:2] == clock_speed_control_addr);

  always_comb begin
    st_next       = st_reg;
    st_next.osc_d = oscillator_input_i;
    st_next.ack   = 1'b0;
    if (!st_reg.boot_done) begin
      st_next.boot_done = 1'b1;
      if (boot_double_speed_fuse_i) begin
        st_next.ctrl    = boot_double_speed_rst; // [RULE_07]
        st_next.eff_cpu = 1'b1; // [RULE_07]
      end
    end
    if (osc_rise) begin
      st_next.half = ~st_reg.half; // [RULE_01]
    end
    // boot cycle owns the mode; a coinciding halved edge must not undo the fuse
    if (half_rise && st_reg.boot_done) begin
      st_next.eff_cpu = st_reg.ctrl[cpu_double_speed_bit]; // [RULE_06]
    end
    // bypass passes oscillator straight; otherwise the halved clock
    st_next.core_clk = st_reg.eff_cpu ? oscillator_input_i : st_next.half; // [RULE_01]
    if (cyc_i && stb_i && !st_reg.ack) begin
      st_next.ack = 1'b1;
      st_next.dat = 32'h0;
      if (hit) begin
        if (we_i && sel_i[0]) begin
          st_next.ctrl = dat_i[7:0] & clock_speed_control_mask;
        end
        st_next.dat = {24'h0, st_reg.ctrl};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg      <= '0;
      st_reg.ctrl <= clock_speed_control_rst; // [RULE_03]
      // track the pin in reset so no false rise follows release
      st_reg.osc_d <= oscillator_input_i;
    end else begin
      st_reg <= st_next;
    end
  end

  // peripherals double only with cpu bit set and own selector clear
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      per_dbl[i] = st_reg.ctrl[cpu_double_speed_bit] &
                   ~st_reg.ctrl[periph_sel_lsb + i]; // [RULE_04] [RULE_05] [RULE_09]
    end
  end

  cycle_strobe u_cpu (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .osc_en_i    (osc_rise),
    .half_edge_i (half_rise),
    .double_i    (st_reg.ctrl[cpu_double_speed_bit]),
    .cycle_o     (cpu_cyc)
  );

  for (genvar g = 0; g < NP; g++) begin : g_per
    cycle_strobe u_per (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .osc_en_i    (osc_rise),
      .half_edge_i (half_rise),
      .double_i    (per_dbl[g]),
      .cycle_o     (per_cyc[g])
    );
  end

  assign dat_o              = st_reg.dat;
  assign ack_o              = st_reg.ack;
  assign core_clk_o         = st_reg.core_clk;
  assign cpu_cycle_o        = cpu_cyc;
  assign periph_cycle_o     = per_cyc;
  assign cpu_double_speed_o = st_reg.eff_cpu;
endmodule : double_speed_clock_generator

/* File: verilog/clock_speed_pkg.sv */
// What this block does
// (RULE_01) standard mode halves oscillator; software bypasses halving
// (RULE_02) cpu bit: clear 12, set 6 periods
// (RULE_03) reset: standard speed, control register zero
// (RULE_04) cpu bit speeds cpu and every peripheral whose selector is clear
// (RULE_05) peripheral doubles only while its selector clear
// (RULE_06) speed change applied on halved-clock rising edge
// (RULE_07) boot fuse programmed: leave reset double speed
// (RULE_08) double-speed peripheral gets halved time reference
// (RULE_09) selectors matter only while cpu bit set
// (RULE_10) selector changes also on halved-clock edge
package clock_speed_pkg;
  localparam logic [7:0] clock_speed_control_addr = 8'h8f;
  localparam logic [7:0] clock_speed_control_rst  = 8'h00;
  localparam logic [7:0] clock_speed_control_mask = 8'h7f;
  localparam logic [7:0] boot_double_speed_rst    = 8'h01;
  localparam int         cpu_double_speed_bit     = 0;
  localparam int         periph_sel_lsb           = 1;
  localparam int         num_periph               = 6;
  localparam logic [3:0] std_periods              = 4'hc;
  localparam logic [3:0] x2_periods               = 4'h6;
  localparam logic [3:0] phase_half               = 4'h3;
endpackage : clock_speed_pkg

/* File: verilog/cycle_strobe.sv */
module cycle_strobe
  import clock_speed_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       osc_en_i,
  input  wire logic       half_edge_i,
  input  wire logic       double_i,
  output logic            cycle_o
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       dbl;
    logic       cyc;
  } cs_s;
  cs_s st_reg, st_next;

  always_comb begin
    st_next     = st_reg;
    st_next.cyc = 1'b0;
    if (half_edge_i) begin
      st_next.dbl = double_i; // [RULE_06] [RULE_10]
    end
    if (osc_en_i) begin
      if (st_reg.cnt + 4'h1 >= (st_reg.dbl ? x2_periods : std_periods)) begin // [RULE_02] [RULE_08]
        st_next.cnt = 4'h0;
        st_next.cyc = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cycle_o = st_reg.cyc;
endmodule : cycle_strobe

/* File: sim/osc_src.sv */
module osc_src #(parameter int HP = 2) (
  input  wire logic clk_i,
  output logic      osc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int   c = 0;
  logic o = 1'b0;
  // free running; HP of 2 keeps it under clk/2
  always @(posedge clk_i) begin
    c <= (c + 1) % HP;
    if (c == HP - 1) o <= !o;
  end
  assign osc_o = o;
endmodule : osc_src

/* File: sim/dsc_chk.sv */
module dsc_chk
  import clock_speed_pkg::*;
#(parameter int NP = num_periph) (
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic          boot_double_speed_fuse_i,
  input wire logic          we_i,
  input wire logic          cyc_i,
  input wire logic          stb_i,
  input wire logic          ack_o,
  input wire logic          core_clk_o,
  input wire logic          cpu_cycle_o,
  input wire logic          cpu_double_speed_o,
  input wire logic [3:0]    sel_i,
  input wire logic [31:0]   adr_i,
  input wire logic [31:0]   dat_i,
  input wire logic [31:0]   dat_o,
  input wire logic [NP-1:0] periph_cycle_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] r;
  logic       q;
  wire        f1 = cpu_double_speed_o && !r[2];
  wire        s5 = cpu_double_speed_o && r[6];
  wire        wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // written byte, not the synchronised one
  always_ff @(posedge clk_i) begin
    q <= rst_i;
    if (rst_i) r <= clock_speed_control_rst;
    else if (q) r <= {7'h0, boot_double_speed_fuse_i};
    else if (wr && adr_i[9:2] == clock_speed_control_addr) r <= dat_i[7:0] & 8'h7f;
  end
  AST_CPU_SLOW: assert property (
    cpu_cycle_o && !cpu_double_speed_o ##48 !cpu_double_speed_o |-> cpu_cycle_o) else $error("cpu gap");
  AST_CPU_FAST: assert property (
    cpu_cycle_o && cpu_double_speed_o ##24 cpu_double_speed_o |-> cpu_cycle_o) else $error("cpu gap");
  AST_PER_FAST: assert property (
    $past(f1, 12) && periph_cycle_o[1] && f1 ##24 f1 |-> periph_cycle_o[1]) else $error("per gap");
  AST_PER_SEL: assert property (
    $past(s5, 12) && periph_cycle_o[5] && s5 ##48 s5 |-> periph_cycle_o[5]) else $error("per gap");
  AST_CORE_HALF: assert property (
    $rose(core_clk_o) ##0 !cpu_double_speed_o [*4] |-> core_clk_o) else $error("core high");
  AST_NO_GLITCH: assert property (
    $changed(core_clk_o) |=> $stable(core_clk_o)) else $error("core glitch");
  AST_MODE_LAT: assert property (
    r[0] != cpu_double_speed_o |-> ##[1:12] r[0] == cpu_double_speed_o) else $error("mode lag");
  AST_READ: assert property (
    ack_o && !we_i && adr_i[9:2] == 8'h8f |-> dat_o == {24'h0, r}) else $error("read");
  cover property (cpu_double_speed_o && cpu_cycle_o);
  cover property (s5 && periph_cycle_o[5]);
  cover property (ack_o && we_i);
endmodule : dsc_chk

bind double_speed_clock_generator dsc_chk #(.NP(NP)) u_chk (.*);

/* File: sim/double_speed_clock_generator_tb_top.sv */
module double_speed_clock_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] RA = 32'h23c;
  logic clk_i = 0, rst_i = 1, fuse = 0, we = 0, cyc = 0, stb = 0;
  logic ack_o, core_clk, cpu_cyc, mode, osc;
  logic [31:0] adr = 0, dat = 0, dat_o, q;
  logic [3:0] sel = 4'h1;
  logic [5:0] pc;
  logic core_d = 0;
  wire core_rise = core_clk & ~core_d;
  wire [7:0] cv = {core_rise, pc, cpu_cyc};
  always @(posedge clk_i) core_d <= core_clk;
  int error_cnt = 0, n_tests = 0, n;
  osc_src u_osc (.clk_i(clk_i), .osc_o(osc));
  double_speed_clock_generator dut (.clk_i(clk_i), .rst_i(rst_i), .oscillator_input_i(osc),
    .boot_double_speed_fuse_i(fuse), .adr_i(adr), .dat_i(dat), .sel_i(sel), .we_i(we),
    .cyc_i(cyc), .stb_i(stb), .dat_o(dat_o), .ack_o(ack_o), .core_clk_o(core_clk),
    .cpu_cycle_o(cpu_cyc), .periph_cycle_o(pc), .cpu_double_speed_o(mode));
  initial forever #25 clk_i = !clk_i;
  task automatic ck(string m, logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", m, e, s);
    end
  endtask : ck
  task automatic wb(logic w, logic [31:0] a, d, logic [3:0] s = 4'h1);
    @(posedge clk_i);
    {we, cyc, stb, adr, dat, sel} <= {w, 2'h3, a, d, s};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    {cyc, stb} <= 2'h0;
  endtask : wb
  // skip pulses first: the cycle in flight at a switch is odd
  task automatic gap(int b);
    repeat (3) do @(posedge clk_i); while (cv[b] !== 1'b1);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (cv[b] !== 1'b1);
  endtask : gap
  task automatic t_slow;
    wb(1, 32'h240, 32'hff);
    wb(0, RA, 0);
    ck("ctl", q, 0);
    wb(0, 32'h240, 0);
    ck("unmap", q, 0);
    wb(1, RA, 32'h80);
    wb(1, RA, 32'h7e, 4'h2);
    wb(0, RA, 0);
    ck("refused", q, 0);
    gap(0);
    ck("cpu", n, 48);
    gap(1);
    ck("per", n, 48);
    gap(7);
    ck("core", n, 8);
    wb(1, RA, 32'h7e);
    wb(0, RA, 0);
    ck("ctl", q, 32'h7e);
    gap(1);
    ck("per", n, 48);
    gap(0);
    ck("cpu", n, 48);
    $display("t_slow done");
  endtask : t_slow
  task automatic t_fast;
    wb(1, RA, 1);
    gap(0);
    ck("cpu", n, 24);
    gap(7);
    ck("core", n, 4);
    for (int j = 0; j < 6; j++) begin
      wb(1, RA, 32'h1 | (32'h2 << j));
      gap(j + 1);
      ck("sel", n, 48);
      gap((j + 1) % 6 + 1);
      ck("per", n, 24);
    end
    $display("t_fast done");
  endtask : t_fast
  task automatic t_fuse;
    {fuse, rst_i} <= 2'h3;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wb(0, RA, 0);
    ck("ctl", q, 1);
    ck("mode", mode, 1);
    gap(0);
    ck("cpu", n, 24);
    $display("t_fuse done");
  endtask : t_fuse
  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    t_slow;
    t_fast;
    t_fuse;
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    close_out;
  end
endmodule : double_speed_clock_generator_tb_top
